// ==== rtl/sms_port.sv ====
// Byte-wide four-line serial port, master or slave, with a Wishbone register slave
`timescale 1ns/1ns
`include "sms_consts.svh"

// Function
// - Finished byte sets transfer_done_flag; only software clears it.
// - Master with interface_on: data write starts full-duplex transfer, own clock.
// - Slave shifts shift_data_reg out and serial_in_line in on master edges.
// - Port keeps running whenever its selected clock source runs.
// - Slave with select_pin_on clear is always selected, ignoring chip_select_n.
// - With select_pin_on clear chip_select_n has no control over the port.
// - Enabled with select pin: serial_in floats, serial_out high when idle.
// - Master drives clock at chosen idle level; slave leaves clock floating.
// - Clearing interface_on releases all four lines and stops the port.
// - Bit order must match the peer device.
// - Received bits gather in a buffer, latched to data only when complete.
// - Data write during transfer sets write_collision_flag and is dropped.
// - Role code picks master clock /4,/16,/64, sub, timer/2, or slave.
// - Idle level and capture edge follow idle-low and edge selects.
// - msb_first_sel one shifts MSB first, zero LSB first, both directions.
// - Slave select rising mid-byte sets incomplete_flag with transfer_done_flag.
module sms_port
  import sms_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [7:0] wb_dat_i,
  input wire logic [0:0] wb_sel_i,
  output logic [7:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic serial_clock_line_i,
  output logic serial_clock_line_o,
  output logic serial_clock_line_oe_n,
  input wire logic serial_in_line_i,
  output logic serial_out_line_o,
  output logic serial_out_line_oe_n,
  input wire logic chip_select_n,
  input wire logic sub_clock_i,
  input wire logic timer_match_i
);

  // ----------------------------------------
  // State and helpers
  // ----------------------------------------
  localparam sms_state_s SMS_RST = '{
    role_clock_select: `SMS_MODE_RST,
    ph: SMS_IDLE,
    sck: 1'b1,
    sck_oe_n: 1'b1,
    sdo: 1'b1,
    sdo_oe_n: 1'b1,
    csn_y: 3'h7,
    default: '0
  };

  sms_state_s st_r;
  sms_state_s st_nxt;
  logic acc;
  logic is_master;
  logic is_slave;
  logic selected;
  logic cap_rise;
  logic tick;
  logic edge_now;
  logic new_lvl;
  logic sdi_s;
  logic [7:0] rx_new;
  logic [7:0] rd_mux;
  logic m_cap;
  logic s_cap;

  // Register outputs straight out of the state
  assign wb_dat_o = st_r.rdat;
  assign wb_ack_o = st_r.ack;
  assign serial_clock_line_o = st_r.sck;
  assign serial_clock_line_oe_n = st_r.sck_oe_n;
  assign serial_out_line_o = st_r.sdo;
  assign serial_out_line_oe_n = st_r.sdo_oe_n;

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    st_nxt = st_r;
    rx_new = st_r.rx_sh;
    rd_mux = 8'h00;
    tick = 1'b0;
    edge_now = 1'b0;
    new_lvl = 1'b0;
    // Pins pass two flops; the first is read by the second only
    st_nxt.sck_y = {st_r.sck_y[1:0], serial_clock_line_i};
    st_nxt.sdi_y = {st_r.sdi_y[0], serial_in_line_i};
    st_nxt.csn_y = {st_r.csn_y[1:0], chip_select_n};
    st_nxt.sub_y = {st_r.sub_y[1:0], sub_clock_i};
    sdi_s = st_r.sdi_y[1];
    // Undefined role codes leave the port inert
    is_master = st_r.interface_on && (st_r.role_clock_select <= `SMS_MODE_TMR);
    is_slave = st_r.interface_on && (st_r.role_clock_select == `SMS_MODE_SLAVE);
    selected = !st_r.select_pin_on || !st_r.csn_y[1];
    cap_rise = !(st_r.clock_idle_low_sel ^ st_r.capture_edge_sel);

    // Read mux; reserved bits read as zero
    case (wb_adr_i)
      `SMS_OFF_CTRL_ZERO:
      begin
        rd_mux = {st_r.role_clock_select, 3'h0, st_r.interface_on, st_r.incomplete_flag};
      end
      `SMS_OFF_CTRL_ONE:
      begin
        rd_mux = {2'h0, st_r.clock_idle_low_sel, st_r.capture_edge_sel, st_r.msb_first_sel,
                  st_r.select_pin_on, st_r.write_collision_flag, st_r.transfer_done_flag};
      end
      `SMS_OFF_DATA:
      begin
        rd_mux = st_r.shift_data_reg;
      end
      default:
      begin
        rd_mux = 8'h00;
      end
    endcase

    // Bus slave: one wait state, ack drops the cycle after
    acc = wb_cyc_i && wb_stb_i && !st_r.ack;
    st_nxt.ack = acc;
    if (acc)
    begin
      st_nxt.rdat = rd_mux;
    end
    if (acc && wb_we_i && wb_sel_i[0])
    begin
      case (wb_adr_i)
        `SMS_OFF_CTRL_ZERO:
        begin
          st_nxt.role_clock_select = wb_dat_i[`SMS_C0_MODE_LSB +: 3];
          st_nxt.interface_on = wb_dat_i[`SMS_C0_ON];
          st_nxt.incomplete_flag = wb_dat_i[`SMS_C0_ICF];
        end
        `SMS_OFF_CTRL_ONE:
        begin
          st_nxt.clock_idle_low_sel = wb_dat_i[`SMS_C1_POL];
          st_nxt.capture_edge_sel = wb_dat_i[`SMS_C1_EDGE];
          st_nxt.msb_first_sel = wb_dat_i[`SMS_C1_MSB];
          st_nxt.select_pin_on = wb_dat_i[`SMS_C1_CSEN];
          st_nxt.write_collision_flag = wb_dat_i[`SMS_C1_WCOL];
          st_nxt.transfer_done_flag = wb_dat_i[`SMS_C1_DONE];
        end
        `SMS_OFF_DATA:
        begin
          if (st_r.ph == SMS_BUSY)
          begin
            st_nxt.write_collision_flag = 1'b1;
          end
          else
          begin
            st_nxt.shift_data_reg = wb_dat_i;
            st_nxt.tx_sh = wb_dat_i;
            if (is_master)
            begin
              st_nxt.ph = SMS_BUSY;
              st_nxt.cnt = 4'h0;
              st_nxt.tog = 5'h00;
              st_nxt.div = 6'h00;
            end
          end
        end
        default:
        begin
          st_nxt.ack = acc;
        end
      endcase
    end

    // Master bit clock from the selected source
    case (st_r.role_clock_select)
      `SMS_MODE_DIV4:
      begin
        tick = (st_r.div == `SMS_HALF_DIV4);
      end
      `SMS_MODE_DIV16:
      begin
        tick = (st_r.div == `SMS_HALF_DIV16);
      end
      `SMS_MODE_DIV64:
      begin
        tick = (st_r.div == `SMS_HALF_DIV64);
      end
      `SMS_MODE_SUB:
      begin
        tick = st_r.sub_y[1] ^ st_r.sub_y[2];
      end
      `SMS_MODE_TMR:
      begin
        tick = timer_match_i; // Each match is half a period: clock is match rate /2
      end
      default:
      begin
        tick = 1'b0;
      end
    endcase
    // Toggling stops after the last edge; div then rests at zero
    if (is_master && st_r.ph == SMS_BUSY && st_r.tog != `SMS_LAST_TOGGLE + 5'h01)
    begin
      // Saturates, so a slow sub clock or timer never wraps it back to zero
      if (tick)
      begin
        st_nxt.div = 6'h00;
      end
      else if (st_r.div != 6'h3F)
      begin
        st_nxt.div = st_r.div + 6'h01;
      end
      edge_now = tick;
      new_lvl = !st_r.sck;
    end
    else if (is_slave && selected && st_r.sck_y[1] != st_r.sck_y[2])
    begin
      edge_now = 1'b1;
      new_lvl = st_r.sck_y[1];
    end

    // Master samples one clock after its capture toggle: the data pin passes
    // two flops, so at /4 the toggle clock itself would still see the old bit
    m_cap = is_master && st_r.ph == SMS_BUSY && st_r.tog != 5'h00 && st_r.div == 6'h00
            && st_r.sck == cap_rise;
    s_cap = edge_now && is_slave && new_lvl == cap_rise;

    // Shift engine shared by both roles
    if (edge_now && new_lvl != cap_rise && st_r.cnt != 4'h0)
    begin
      // Launch only after a capture, so the first bit stays put
      st_nxt.tx_sh = st_r.msb_first_sel ? {st_r.tx_sh[6:0], 1'b0} : {1'b0, st_r.tx_sh[7:1]};
    end
    if (m_cap || s_cap)
    begin
      rx_new = st_r.msb_first_sel ? {st_r.rx_sh[6:0], sdi_s} : {sdi_s, st_r.rx_sh[7:1]};
      st_nxt.rx_sh = rx_new;
      st_nxt.cnt = st_r.cnt + 4'h1;
    end
    if (is_master && edge_now)
    begin
      st_nxt.sck = new_lvl;
      st_nxt.tog = st_r.tog + 5'h01;
    end
    // Master ends the clock after its sixteenth toggle, once the last sample is in
    if (is_master && st_r.ph == SMS_BUSY && st_r.tog == `SMS_LAST_TOGGLE + 5'h01)
    begin
      st_nxt.ph = SMS_IDLE;
      st_nxt.shift_data_reg = rx_new;
      st_nxt.transfer_done_flag = 1'b1;
    end
    if (is_slave && edge_now)
    begin
      st_nxt.ph = SMS_BUSY;
      if (s_cap && st_r.cnt == `SMS_LAST_BIT)
      begin
        st_nxt.ph = SMS_IDLE;
        st_nxt.cnt = 4'h0;
        st_nxt.shift_data_reg = rx_new;
        st_nxt.transfer_done_flag = 1'b1;
      end
    end

    // Slave deselect; an early rise aborts and flags the byte
    if (is_slave && st_r.select_pin_on && st_r.csn_y[1])
    begin
      st_nxt.cnt = 4'h0;
      if (!st_r.csn_y[2] && st_r.ph == SMS_BUSY)
      begin
        st_nxt.incomplete_flag = 1'b1;
        st_nxt.transfer_done_flag = 1'b1;
      end
      st_nxt.ph = SMS_IDLE;
    end

    // Disable or an undefined role code drops any transfer in flight
    if (!is_master && !is_slave)
    begin
      st_nxt.ph = SMS_IDLE;
      st_nxt.cnt = 4'h0;
    end

    // Idle clock level while master but not shifting
    if (st_nxt.ph == SMS_IDLE)
    begin
      st_nxt.sck = !st_nxt.clock_idle_low_sel;
    end

    // Pin drive: active-low enables, released when off
    st_nxt.sck_oe_n = !is_master;
    st_nxt.sdo_oe_n = !st_r.interface_on;
    if (st_nxt.ph == SMS_BUSY || (is_slave && selected))
    begin
      st_nxt.sdo = st_nxt.msb_first_sel ? st_nxt.tx_sh[7] : st_nxt.tx_sh[0];
    end
    else
    begin
      st_nxt.sdo = 1'b1;
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge ref_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= SMS_RST;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

endmodule : sms_port

// ==== rtl/sms_consts.svh ====
// Offsets, field positions, reset values and timing counts of the serial port
`ifndef SMS_CONSTS_SVH
`define SMS_CONSTS_SVH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define SMS_OFF_CTRL_ZERO 4'h0
`define SMS_OFF_CTRL_ONE 4'h4
`define SMS_OFF_DATA 4'h8

// ----------------------------------------
// Field positions of ctrl_reg_zero
// ----------------------------------------
`define SMS_C0_MODE_LSB 5
`define SMS_C0_ON 1
`define SMS_C0_ICF 0

// ----------------------------------------
// Field positions of ctrl_reg_one
// ----------------------------------------
`define SMS_C1_POL 5
`define SMS_C1_EDGE 4
`define SMS_C1_MSB 3
`define SMS_C1_CSEN 2
`define SMS_C1_WCOL 1
`define SMS_C1_DONE 0

// ----------------------------------------
// Role and clock source codes
// ----------------------------------------
`define SMS_MODE_DIV4 3'h0
`define SMS_MODE_DIV16 3'h1
`define SMS_MODE_DIV64 3'h2
`define SMS_MODE_SUB 3'h3
`define SMS_MODE_TMR 3'h4
`define SMS_MODE_SLAVE 3'h5
`define SMS_MODE_RST 3'h7

// ----------------------------------------
// Half serial period in system clocks, minus one
// ----------------------------------------
`define SMS_HALF_DIV4 6'h01
`define SMS_HALF_DIV16 6'h07
`define SMS_HALF_DIV64 6'h1F

// ----------------------------------------
// Transfer length
// ----------------------------------------
`define SMS_LAST_BIT 4'h7
`define SMS_LAST_TOGGLE 5'h0F

`endif

// ==== rtl/sms_pkg.sv ====
// Types shared by the serial port design
package sms_pkg;

  // ----------------------------------------
  // Transfer phase, one-hot
  // ----------------------------------------
  typedef enum logic [1:0] {
    SMS_IDLE = 2'b01,
    SMS_BUSY = 2'b10
  } sms_phase_e;

  // ----------------------------------------
  // Whole state of the port
  // ----------------------------------------
  typedef struct packed {
    logic [2:0] role_clock_select;
    logic interface_on;
    logic incomplete_flag;
    logic clock_idle_low_sel;
    logic capture_edge_sel;
    logic msb_first_sel;
    logic select_pin_on;
    logic write_collision_flag;
    logic transfer_done_flag;
    logic [7:0] shift_data_reg;
    logic [7:0] tx_sh;
    logic [7:0] rx_sh;
    sms_phase_e ph;
    logic [3:0] cnt;
    logic [4:0] tog;
    logic [5:0] div;
    logic sck;
    logic sck_oe_n;
    logic sdo;
    logic sdo_oe_n;
    logic ack;
    logic [7:0] rdat;
    logic [2:0] sck_y;
    logic [1:0] sdi_y;
    logic [2:0] csn_y;
    logic [2:0] sub_y;
  } sms_state_s;

endpackage : sms_pkg

// ==== verif/sms_port_monitor.sv ====
// Bus and pin checker of the serial port
`timescale 1ns/1ns
module sms_port_monitor
  import sms_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [3:0] wb_adr_i,
  input wire logic [7:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic serial_clock_line_o,
  input wire logic serial_clock_line_oe_n,
  input wire logic serial_out_line_o,
  input wire logic serial_out_line_oe_n
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  logic [4:0] tog_r;
  // Clock toggles since the last data write; released clock restarts the count
  always_ff @(posedge ref_clk or negedge resetn)
    if (!resetn)
      tog_r <= 5'h00;
    else if (serial_clock_line_oe_n || (wb_ack_o && wb_we_i && wb_adr_i == 4'h8))
      tog_r <= 5'h00;
    else if (serial_clock_line_o != $past(serial_clock_line_o))
      tog_r <= tog_r + 5'h01;
  // Bus handshake
  property p_ack_resp; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o; endproperty
  a_ack_resp: assert property (p_ack_resp) else $error("ack missing");
  property p_ack_once; wb_ack_o |=> !wb_ack_o; endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack too long");
  property p_ack_cause; $rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i); endproperty
  a_ack_cause: assert property (p_ack_cause) else $error("ack without request");
  property p_no_req; !wb_cyc_i ##1 !wb_cyc_i |-> !wb_ack_o; endproperty
  a_no_req: assert property (p_no_req) else $error("ack while idle");
  property p_dat_hold; !wb_cyc_i |=> $stable(wb_dat_o); endproperty
  a_dat_hold: assert property (p_dat_hold) else $error("read data moved");
  // Pin drive
  property p_oe_pair; !serial_clock_line_oe_n |-> !serial_out_line_oe_n; endproperty
  a_oe_pair: assert property (p_oe_pair) else $error("clock driven while port off");
  property p_sdo_rel; serial_out_line_oe_n |-> serial_out_line_o; endproperty
  a_sdo_rel: assert property (p_sdo_rel) else $error("data out not high");
  property p_tog_max; tog_r <= 5'h10; endproperty
  a_tog_max: assert property (p_tog_max) else $error("more than sixteen clock toggles");
endmodule : sms_port_monitor

// ==== verif/sms_peer.sv ====
// Behavioural serial peripheral answering the port in master role
`timescale 1ns/1ns
module sms_peer
  import sms_pkg::*;
(
  input wire logic sck,
  input wire logic mosi,
  input wire logic go,
  input wire logic pol,
  input wire logic edg,
  input wire logic msb,
  input wire logic [7:0] txd,
  output logic miso,
  output logic [7:0] rxd
);
  logic [7:0] sh = 8'h00;
  integer n = 0;
  // Frame start loads the reply byte
  always @(go)
  begin
    sh = txd;
    n = 0;
  end
  // Capture on the chosen edge, launch on the other after the first capture
  always @(sck)
  begin
    if (sck == (pol == edg))
    begin
      rxd = msb ? {rxd[6:0], mosi} : {mosi, rxd[7:1]};
      n = n + 1;
    end
    else if (n > 0)
      sh = msb ? {sh[6:0], ~sh[0]} : {~sh[7], sh[7:1]};
  end
  // Filler bits invert, so stale data never looks valid
  assign miso = msb ? sh[7] : sh[0];
endmodule : sms_peer

// ==== verif/testbench.sv ====
// Self-checking bench for the serial port in both roles
`timescale 1ns/1ns
module testbench
  import sms_pkg::*;
;
  logic ref_clk = 1'b0, resetn = 1'b0, cyc = 1'b0, stb = 1'b0, we = 1'b0, sel = 1'b0;
  logic b_sck = 1'b1, b_sdi = 1'b0, csn = 1'b1, sub = 1'b0, tmr = 1'b0, go = 1'b0, slv = 1'b0;
  logic pol = 1'b0, edg = 1'b0, msb = 1'b0;
  logic [3:0] adr = 4'h0;
  logic [2:0] sc = 3'h0;
  logic [7:0] dat = 8'h00, ptx = 8'h00, rd, rx;
  wire logic sck_o, sck_oe_n, sdo_o, sdo_oe_n, miso, ack;
  wire logic [7:0] dat_o, prx;
  int failures = 0, checks = 0, n;
  // Rows: we, sel, address, write data, expected read
  logic [21:0] rows [0:8] = '{{2'h1, 4'h0, 8'h00, 8'hE0}, {2'h1, 4'h4, 8'h00, 8'h00},
    {2'h1, 4'h8, 8'h00, 8'h00}, {2'h2, 4'h4, 8'h3C, 8'h00}, {2'h1, 4'h4, 8'h00, 8'h00},
    {2'h3, 4'hC, 8'hFF, 8'h00}, {2'h1, 4'hC, 8'h00, 8'h00}, {2'h3, 4'h8, 8'h5A, 8'h00},
    {2'h1, 4'h8, 8'h00, 8'h5A}};
  logic [7:0] cfg [0:4] = '{8'h0C, 8'h34, 8'h14, 8'h2C, 8'h1C};
  // Shared pin levels: whoever is enabled drives
  wire logic sck_w = !sck_oe_n ? sck_o : b_sck;
  wire logic sdi_w = slv ? b_sdi : miso;
  always #20 ref_clk = ~ref_clk;
  // Sub clock edge and timer pulse every five cycles
  always @(posedge ref_clk)
  begin
    sc <= (sc == 3'h4) ? 3'h0 : sc + 3'h1;
    sub <= sub ^ (sc == 3'h4);
    tmr <= (sc == 3'h2);
  end
  sms_port dut_u (.ref_clk(ref_clk), .resetn(resetn), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .serial_clock_line_i(sck_w), .serial_clock_line_o(sck_o), .serial_clock_line_oe_n(sck_oe_n),
    .serial_in_line_i(sdi_w), .serial_out_line_o(sdo_o), .serial_out_line_oe_n(sdo_oe_n),
    .chip_select_n(csn), .sub_clock_i(sub), .timer_match_i(tmr));
  sms_peer peer_u (.sck(sck_w), .mosi(sdo_o), .go(go), .pol(pol), .edg(edg), .msb(msb), .txd(ptx),
    .miso(miso), .rxd(prx));
  task give_verdict;
    $display("checks %0d failures %0d", checks, failures);
    if (failures == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : give_verdict
  task chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e)
    begin
      failures++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  // One classic cycle: request held until ack is sampled high at a rising edge
  task wb(input logic w, input logic s, input logic [3:0] a, input logic [7:0] d);
    int k;
    k = 0;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    sel <= s;
    adr <= a;
    dat <= d;
    do @(posedge ref_clk); while (ack !== 1'b1 && ++k < 100);
    chk("ack", 8'h01, {7'h00, ack});
    rd = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge ref_clk);
  endtask : wb
  // Bench as remote master: 320 ns clock, idle high, capture on rising edge
  task sframe(input logic [7:0] d, input logic [7:0] si, input int nb, input logic cs);
    wb(1'b1, 1'b1, 4'h8, d);
    csn <= cs;
    rx = 8'h00;
    repeat (4) @(posedge ref_clk);
    for (int b = 0; b < nb; b++)
    begin
      b_sck <= 1'b0;
      b_sdi <= si[7 - b];
      repeat (3) @(posedge ref_clk);
      @(negedge ref_clk) rx = {rx[6:0], sdo_o};
      @(posedge ref_clk) b_sck <= 1'b1;
      repeat (4) @(posedge ref_clk);
    end
    csn <= 1'b1;
    b_sdi <= ~b_sdi;
    repeat (6) @(posedge ref_clk);
  endtask : sframe
  initial
  begin
    #800000;
    failures++;
    give_verdict();
  end
  initial
  begin
    repeat (3) @(posedge ref_clk);
    resetn <= 1'b1;
    @(posedge ref_clk);
    for (int i = 0; i < 9; i++)
    begin
      wb(rows[i][21], rows[i][20], rows[i][19:16], rows[i][15:8]);
      if (!rows[i][21]) chk("register row", rows[i][7:0], rd);
    end
    // Every master clock source, all idle and edge choices, both orders
    for (int i = 0; i < 5; i++)
    begin
      pol <= cfg[i][5];
      edg <= cfg[i][4];
      msb <= cfg[i][3];
      ptx <= 8'h3C + i[7:0];
      wb(1'b1, 1'b1, 4'h0, 8'hE0);
      chk("released", 8'h03, {6'h00, sck_oe_n, sdo_oe_n});
      wb(1'b1, 1'b1, 4'h4, cfg[i]);
      wb(1'b1, 1'b1, 4'h0, {i[2:0], 5'h02});
      go <= ~go;
      wb(1'b1, 1'b1, 4'h8, 8'hA5 ^ i[7:0]);
      wb(1'b1, 1'b1, 4'h8, 8'h00);
      n = 0;
      do wb(1'b0, 1'b1, 4'h4, 8'h00); while (rd[0] !== 1'b1 && ++n < 300);
      chk("done and collision", cfg[i] | 8'h03, rd);
      wb(1'b0, 1'b1, 4'h8, 8'h00);
      chk("master rx", 8'h3C + i[7:0], rd);
      chk("peer rx", 8'hA5 ^ i[7:0], prx);
      chk("idle lines", {6'h00, ~cfg[i][5], 1'b1}, {6'h00, sck_o, sdo_o});
      wb(1'b1, 1'b1, 4'h4, cfg[i]);
      wb(1'b0, 1'b1, 4'h4, 8'h00);
      chk("flags cleared", cfg[i], rd);
    end
    slv <= 1'b1;
    wb(1'b1, 1'b1, 4'h0, 8'hE0);
    wb(1'b1, 1'b1, 4'h4, 8'h0C);
    wb(1'b1, 1'b1, 4'h0, 8'hA2);
    chk("slave clock released", 8'h01, {7'h00, sck_oe_n});
    sframe(8'h96, 8'h5B, 8, 1'b0);
    wb(1'b0, 1'b1, 4'h4, 8'h00);
    chk("slave done", 8'h0D, rd);
    wb(1'b0, 1'b1, 4'h8, 8'h00);
    chk("slave rx", 8'h5B, rd);
    chk("slave tx", 8'h96, rx);
    // Select lost after three bits
    wb(1'b1, 1'b1, 4'h4, 8'h0C);
    sframe(8'h00, 8'hFF, 3, 1'b0);
    wb(1'b0, 1'b1, 4'h0, 8'h00);
    chk("incomplete", 8'hA3, rd);
    wb(1'b0, 1'b1, 4'h4, 8'h00);
    chk("incomplete done", 8'h0D, rd);
    // Select pin off: select line held high is ignored
    wb(1'b1, 1'b1, 4'h0, 8'hA2);
    wb(1'b1, 1'b1, 4'h4, 8'h08);
    sframe(8'h81, 8'h42, 8, 1'b1);
    wb(1'b0, 1'b1, 4'h8, 8'h00);
    chk("unselected rx", 8'h42, rd);
    // Reset in mid-run: pins released, ack low, registers back to idle values
    resetn <= 1'b0;
    repeat (3) @(posedge ref_clk);
    chk("reset pins", 8'h0E, {4'h0, sck_oe_n, sdo_oe_n, sdo_o, ack});
    resetn <= 1'b1;
    @(posedge ref_clk);
    wb(1'b0, 1'b1, 4'h0, 8'h00);
    chk("reset ctrl zero", 8'hE0, rd);
    wb(1'b0, 1'b1, 4'h4, 8'h00);
    chk("reset ctrl one", 8'h00, rd);
    give_verdict();
  end
endmodule : testbench

bind sms_port sms_port_monitor mon_u (.ref_clk, .resetn, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
  .wb_dat_o, .wb_ack_o, .serial_clock_line_o, .serial_clock_line_oe_n, .serial_out_line_o,
  .serial_out_line_oe_n);
